// *** core/qspi_pkg.sv ***
package qspi_pkg;
    // Geometry of the stage engine
    localparam int DIV_W = 12;
    localparam int DIV_MAX = 4080;
    localparam int LEN_W = 37;
    localparam int LEN_MIN = 8;
    localparam int DLY_W = 3;
    localparam int STAGES = 4;
    localparam int BYTE_BITS = 8;
    // Lane configurations of a stage
    localparam logic [1:0] LANES_SINGLE = 2'h0;
    localparam logic [1:0] LANES_DUAL = 2'h1;
    localparam logic [1:0] LANES_QUAD = 2'h2;
    // Boot straps that free lanes two and three
    localparam logic [1:0] BOOT_MODE_ONE = 2'h1;
    localparam logic [1:0] BOOT_MODE_THREE = 2'h3;
    // Flash command codes carried by the stages
    localparam logic [7:0] CMD_FAST_READ = 8'h0b;
    localparam logic [7:0] CMD_QUAD_OUT_READ = 8'h6b;
    localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] CMD_SECTOR_ERASE = 8'hd8;
    localparam logic [7:0] CMD_BULK_ERASE = 8'hc7;
    localparam logic [7:0] CMD_PAGE_PROGRAM = 8'h02;
    localparam logic [7:0] CMD_QUAD_PAGE_PROGRAM = 8'h32;
    localparam logic [7:0] CMD_READ_STATUS = 8'h05;
    localparam logic [7:0] CMD_READ_CONFIG = 8'h35;
    localparam logic [7:0] CMD_WRITE_STATUS_CONFIG = 8'h01;
    // Reset values
    localparam logic RST_SELECT = 1'b0;
    localparam logic RST_BUSY = 1'b0;

    typedef enum logic [2:0] {ST_IDLE, ST_LEAD, ST_XFER, ST_LAG, ST_GAP} link_state_e;

    // Bits moved per clock for a lane configuration
    function automatic logic [2:0] beat_width(input logic [1:0] lanes);
        beat_width = (lanes == LANES_SINGLE) ? 3'h1 : (lanes == LANES_DUAL) ? 3'h2 : 3'h4;
    endfunction

    // Legal division ratio: clamped, undivided only for multi-lane reads
    function automatic logic [DIV_W-1:0] eff_div(input logic [DIV_W-1:0] div,
                                                 input logic [1:0] lanes,
                                                 input logic rd);
        logic [DIV_W-1:0] d;
        d = (div == '0) ? DIV_W'(1) : div;
        if (d > DIV_W'(DIV_MAX))
            d = DIV_W'(DIV_MAX);
        if (d == DIV_W'(1) && !(rd && lanes != LANES_SINGLE))
            d = DIV_W'(2);
        eff_div = d;
    endfunction
endpackage

// *** core/quad_spi_flash_master.sv ***
`timescale 1ns/1ps
// How it works
// - Each stage picks single, two-lane or four-lane operation.
// - Stage length in bits, eight at least, up to 128 Gbit.
// - Serial clock is the bus clock divided by 2 to 8160 (twice a ratio of 1 to 4080).
// - Division by one is refused for any stage that sends data.
// - Undivided rate only for two- or four-lane receive stages.
// - Four stages run in order from stage zero to the last chosen.
// - Single lane is full duplex: lane zero out, lane one in.
// - Two-lane stages move two bits a clock, half duplex, lanes 0-1.
// - Four-lane stages move four bits a clock, half duplex, lanes 0-3.
// - Single-lane out shares lane zero pin, single-lane in shares lane one.
// - Pins act as general ports until the function select is set.
// - Lanes two and three serve only in boot modes one or three.
// - Polarity and phase one: clock idles high, data moves on falling.
// - Four-lane read: single-lane header, four-lane read dummy, four-lane data.
module quad_spi_flash_master (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic start,
    input wire logic [3:0][1:0] stage_lanes,
    input wire logic [3:0] stage_read,
    input wire logic [3:0] stage_keep_select,
    input wire logic [3:0][qspi_pkg::DIV_W-1:0] bit_rate_divider,
    input wire logic [3:0][qspi_pkg::LEN_W-1:0] stage_len,
    input wire logic [1:0] last_stage,
    input wire logic clock_idle_polarity,
    input wire logic clock_phase_select,
    input wire logic [qspi_pkg::DLY_W-1:0] select_to_clock_delay,
    input wire logic [qspi_pkg::DLY_W-1:0] select_negate_delay,
    input wire logic [qspi_pkg::DLY_W-1:0] next_access_delay,
    input wire logic pin_func_select,
    input wire logic [1:0] boot_mode,
    output logic busy,
    output logic done,
    input wire logic link_clk,
    input wire logic [7:0] tx_byte,
    output logic tx_take,
    output logic [7:0] rx_byte,
    output logic rx_valid,
    input wire logic [5:0] gpio_out,
    input wire logic [5:0] gpio_oe_n,
    output logic serial_master_clock,
    output logic serial_master_clock_oe_n,
    output logic flash_select_line_n,
    output logic flash_select_line_oe_n,
    input wire logic [3:0] lane_in,
    output logic [3:0] lane_out,
    output logic [3:0] lane_oe_n
);
    localparam int W = qspi_pkg::DIV_W;
    localparam int L = qspi_pkg::LEN_W;
    localparam int DW = qspi_pkg::DLY_W;

    // Core side: held stage setup, request toggle, strap capture
    logic [3:0][1:0] h_lanes_q, h_lanes_d;
    logic [3:0] h_read_q, h_read_d, h_keep_q, h_keep_d;
    logic [3:0][W-1:0] h_div_q, h_div_d;
    logic [3:0][L-1:0] h_len_q, h_len_d;
    logic [1:0] h_last_q, h_last_d, strap_q, strap_d;
    logic h_clock_idle_polarity_q, h_clock_idle_polarity_d, h_clock_phase_select_q, h_clock_phase_select_d;
    logic [DW-1:0] h_lead_q, h_lead_d, h_lag_q, h_lag_d, h_gap_q, h_gap_d;
    logic req_tog_q, req_tog_d, busy_q, busy_d, done_q, done_d;
    logic strap_taken_q, strap_taken_d;
    logic done_tog_q, done_tog_d;
    logic dn_s1_q, dn_s2_q, dn_s3_q;
    logic done_evt;
    logic lanes23_ok;

    assign done_evt = dn_s2_q ^ dn_s3_q;
    assign lanes23_ok = (strap_q == qspi_pkg::BOOT_MODE_ONE) ||
                        (strap_q == qspi_pkg::BOOT_MODE_THREE);
    assign busy = busy_q;
    assign done = done_q;

    // Setup is frozen while busy, so the link side may read it as static
    always_comb
    begin
        h_lanes_d = h_lanes_q;
        h_read_d = h_read_q;
        h_keep_d = h_keep_q;
        h_div_d = h_div_q;
        h_len_d = h_len_q;
        h_last_d = h_last_q;
        h_clock_idle_polarity_d = h_clock_idle_polarity_q;
        h_clock_phase_select_d = h_clock_phase_select_q;
        h_lead_d = h_lead_q;
        h_lag_d = h_lag_q;
        h_gap_d = h_gap_q;
        req_tog_d = req_tog_q;
        busy_d = busy_q;
        done_d = 1'b0;
        strap_d = strap_q;
        strap_taken_d = strap_taken_q;
        if (start && !busy_q)
        begin
            h_lanes_d = stage_lanes;
            h_read_d = stage_read;
            h_keep_d = stage_keep_select;
            h_div_d = bit_rate_divider;
            h_len_d = stage_len;
            h_last_d = last_stage;
            h_clock_idle_polarity_d = clock_idle_polarity;
            h_clock_phase_select_d = clock_phase_select;
            h_lead_d = select_to_clock_delay;
            h_lag_d = select_negate_delay;
            h_gap_d = next_access_delay;
            req_tog_d = ~req_tog_q;
            busy_d = 1'b1;
        end
        if (done_evt)
        begin
            busy_d = 1'b0;
            done_d = 1'b1;
        end
        // Strap caught once, on the first enabled edge after release
        if (!strap_taken_q)
        begin
            strap_d = boot_mode;
            strap_taken_d = 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            {h_lanes_q, h_read_q, h_keep_q, h_div_q, h_len_q, h_last_q} <= '0;
            {h_clock_idle_polarity_q, h_clock_phase_select_q, h_lead_q, h_lag_q, h_gap_q, req_tog_q} <= '0;
            busy_q <= qspi_pkg::RST_BUSY;
            {done_q, strap_q, strap_taken_q, dn_s1_q, dn_s2_q, dn_s3_q} <= '0;
        end
        else if (clk_en)
        begin
            h_lanes_q <= h_lanes_d;
            h_read_q <= h_read_d;
            h_keep_q <= h_keep_d;
            h_div_q <= h_div_d;
            h_len_q <= h_len_d;
            h_last_q <= h_last_d;
            h_clock_idle_polarity_q <= h_clock_idle_polarity_d;
            h_clock_phase_select_q <= h_clock_phase_select_d;
            h_lead_q <= h_lead_d;
            h_lag_q <= h_lag_d;
            h_gap_q <= h_gap_d;
            req_tog_q <= req_tog_d;
            busy_q <= busy_d;
            done_q <= done_d;
            strap_q <= strap_d;
            strap_taken_q <= strap_taken_d;
            dn_s1_q <= done_tog_q;
            dn_s2_q <= dn_s1_q;
            dn_s3_q <= dn_s2_q;
        end
    end

    // Link side: synchronisers for request, enable, pin setup and lanes
    logic rq_s1_q, rq_s2_q, rq_s3_q, en_s1_q, en_s2_q;
    logic fn_s1_q, fn_s2_q, l23_s1_q, l23_s2_q;
    logic [3:0] in_s1_q, in_s2_q;

    always_ff @(posedge link_clk or posedge rst)
    begin
        if (rst)
        begin
            {rq_s1_q, rq_s2_q, rq_s3_q, en_s1_q, en_s2_q} <= '0;
            {fn_s1_q, fn_s2_q, l23_s1_q, l23_s2_q, in_s1_q, in_s2_q} <= '0;
        end
        else
        begin
            en_s1_q <= clk_en;
            en_s2_q <= en_s1_q;
            if (en_s2_q)
            begin
                rq_s1_q <= req_tog_q;
                rq_s2_q <= rq_s1_q;
                rq_s3_q <= rq_s2_q;
                fn_s1_q <= pin_func_select;
                fn_s2_q <= fn_s1_q;
                l23_s1_q <= lanes23_ok;
                l23_s2_q <= l23_s1_q;
                in_s1_q <= lane_in;
                in_s2_q <= in_s1_q;
            end
        end
    end

    // Stage engine state
    qspi_pkg::link_state_e state_q, state_d;
    logic [1:0] stage_q, stage_d, nx_stage;
    logic [W-1:0] hp_q, hp_d, cur_div;
    logic [DW:0] dly_q, dly_d;
    logic [L-1:0] bits_q, bits_d;
    logic [3:0] cnt8_q, cnt8_d, lane_q, lane_d;
    logic [7:0] sr_q, sr_d, rxsr_q, rxsr_d, rx_byte_q, rx_byte_d;
    logic rx_valid_q, rx_valid_d, take_q, take_d;
    logic phase_q, phase_d, edge_q, edge_d, sel_q, sel_d;
    logic [1:0] cur_lanes;
    logic [2:0] cur_w;
    logic cur_rd, rx_on, tx_on, tick, start_evt, setup, advance, drive;

    assign cur_lanes = h_lanes_q[stage_q];
    assign cur_rd = h_read_q[stage_q];
    assign cur_w = qspi_pkg::beat_width(cur_lanes);
    assign cur_div = qspi_pkg::eff_div(h_div_q[stage_q], cur_lanes, cur_rd);
    assign rx_on = (cur_lanes == qspi_pkg::LANES_SINGLE) || cur_rd;
    assign tx_on = (cur_lanes == qspi_pkg::LANES_SINGLE) || !cur_rd;
    assign tick = (hp_q == '0);
    assign start_evt = rq_s2_q ^ rq_s3_q;

    // One half period of the serial clock is cur_div link cycles
    always_comb
    begin
        state_d = state_q;
        stage_d = stage_q;
        hp_d = (state_q == qspi_pkg::ST_IDLE) ? hp_q : (tick ? cur_div - W'(1) : hp_q - W'(1));
        dly_d = dly_q;
        bits_d = bits_q;
        cnt8_d = cnt8_q;
        lane_d = lane_q;
        sr_d = sr_q;
        rxsr_d = rxsr_q;
        rx_byte_d = rx_byte_q;
        rx_valid_d = 1'b0;
        take_d = 1'b0;
        phase_d = phase_q;
        edge_d = edge_q;
        sel_d = sel_q;
        done_tog_d = done_tog_q;
        nx_stage = '0;
        setup = 1'b0;
        advance = 1'b0;
        drive = 1'b0;
        unique case (state_q)
            qspi_pkg::ST_IDLE:
                if (start_evt)
                    setup = 1'b1;
            qspi_pkg::ST_LEAD:
                if (tick)
                begin
                    dly_d = dly_q - 1'b1;
                    if (dly_q == '0)
                    begin
                        state_d = qspi_pkg::ST_XFER;
                        drive = !h_clock_phase_select_q;
                    end
                end
            qspi_pkg::ST_XFER:
                if (tick)
                begin
                    phase_d = ~phase_q;
                    edge_d = ~edge_q;
                    // Phase one samples on even edges, phase zero on odd
                    if (edge_q == h_clock_phase_select_q)
                    begin
                        if (cur_w == 3'h4)
                            rxsr_d = {rxsr_q[3:0], in_s2_q};
                        else if (cur_w == 3'h2)
                            rxsr_d = {rxsr_q[5:0], in_s2_q[1:0]};
                        else
                            rxsr_d = {rxsr_q[6:0], in_s2_q[1]};
                        bits_d = bits_q - L'(cur_w);
                        cnt8_d = cnt8_q + 4'(cur_w);
                        if (cnt8_d == 4'(qspi_pkg::BYTE_BITS))
                        begin
                            cnt8_d = '0;
                            rx_byte_d = rx_on ? rxsr_d : rx_byte_q;
                            rx_valid_d = rx_on;
                            if (bits_d != '0 && tx_on)
                            begin
                                sr_d = tx_byte;
                                take_d = 1'b1;
                            end
                        end
                        if (bits_d == '0)
                        begin
                            state_d = qspi_pkg::ST_LAG;
                            dly_d = {h_lag_q, 1'b1};
                        end
                    end
                    else
                        drive = 1'b1;
                end
            qspi_pkg::ST_LAG:
                if (tick)
                begin
                    phase_d = 1'b0;
                    dly_d = dly_q - 1'b1;
                    if (dly_q == '0)
                    begin
                        if (h_keep_q[stage_q])
                            advance = 1'b1;
                        else
                        begin
                            sel_d = qspi_pkg::RST_SELECT;
                            state_d = qspi_pkg::ST_GAP;
                            dly_d = {h_gap_q, 1'b1};
                        end
                    end
                end
            qspi_pkg::ST_GAP:
                if (tick)
                begin
                    dly_d = dly_q - 1'b1;
                    advance = (dly_q == '0);
                end
        endcase
        // Stages loop from zero up to the last one chosen
        if (advance)
        begin
            if (stage_q == h_last_q)
            begin
                state_d = qspi_pkg::ST_IDLE;
                done_tog_d = ~done_tog_q;
            end
            else
            begin
                setup = 1'b1;
                nx_stage = stage_q + 2'h1;
            end
        end
        // Top bits of the shifter onto the lanes, MSB first
        if (drive)
        begin
            if (cur_w == 3'h4)
            begin
                lane_d = sr_q[7:4];
                sr_d = {sr_q[3:0], 4'h0};
            end
            else if (cur_w == 3'h2)
            begin
                lane_d = {2'h0, sr_q[7:6]};
                sr_d = {sr_q[5:0], 2'h0};
            end
            else
            begin
                lane_d = {3'h0, sr_q[7]};
                sr_d = {sr_q[6:0], 1'b0};
            end
        end
        if (setup)
        begin
            stage_d = nx_stage;
            state_d = qspi_pkg::ST_LEAD;
            sel_d = 1'b1;
            hp_d = qspi_pkg::eff_div(h_div_q[nx_stage], h_lanes_q[nx_stage],
                                     h_read_q[nx_stage]) - W'(1);
            dly_d = {h_lead_q, 1'b1};
            bits_d = (h_len_q[nx_stage] < L'(qspi_pkg::LEN_MIN)) ?
                     L'(qspi_pkg::LEN_MIN) : h_len_q[nx_stage];
            cnt8_d = '0;
            phase_d = 1'b0;
            edge_d = 1'b0;
            if (h_lanes_q[nx_stage] == qspi_pkg::LANES_SINGLE || !h_read_q[nx_stage])
            begin
                sr_d = tx_byte;
                take_d = 1'b1;
            end
        end
    end

    always_ff @(posedge link_clk or posedge rst)
    begin
        if (rst)
        begin
            state_q <= qspi_pkg::ST_IDLE;
            {stage_q, hp_q, dly_q, bits_q, cnt8_q, lane_q, sr_q, rxsr_q} <= '0;
            {rx_byte_q, rx_valid_q, take_q, phase_q, edge_q, done_tog_q} <= '0;
            sel_q <= qspi_pkg::RST_SELECT;
        end
        else if (en_s2_q)
        begin
            state_q <= state_d;
            stage_q <= stage_d;
            hp_q <= hp_d;
            dly_q <= dly_d;
            bits_q <= bits_d;
            cnt8_q <= cnt8_d;
            lane_q <= lane_d;
            sr_q <= sr_d;
            rxsr_q <= rxsr_d;
            rx_byte_q <= rx_byte_d;
            rx_valid_q <= rx_valid_d;
            take_q <= take_d;
            phase_q <= phase_d;
            edge_q <= edge_d;
            sel_q <= sel_d;
            done_tog_q <= done_tog_d;
        end
    end

    assign tx_take = take_q;
    assign rx_byte = rx_byte_q;
    assign rx_valid = rx_valid_q;

    // Pin multiplexing; half-duplex reads release every lane
    logic [3:0] drv;
    always_comb
    begin
        drv = '0;
        if (state_q != qspi_pkg::ST_IDLE)
        begin
            if (cur_lanes == qspi_pkg::LANES_SINGLE)
                drv = 4'h1;
            else if (!cur_rd)
                drv = (cur_w == 3'h4) ? 4'hf : 4'h3;
        end
        serial_master_clock = fn_s2_q ? (h_clock_idle_polarity_q ^ phase_q) : gpio_out[0];
        serial_master_clock_oe_n = fn_s2_q ? 1'b0 : gpio_oe_n[0];
        flash_select_line_n = fn_s2_q ? ~sel_q : gpio_out[1];
        flash_select_line_oe_n = fn_s2_q ? 1'b0 : gpio_oe_n[1];
        for (int i = 0; i < 4; i++)
        begin
            if (fn_s2_q && (i < 2 || l23_s2_q))
            begin
                lane_out[i] = lane_q[i];
                lane_oe_n[i] = ~drv[i];
            end
            else
            begin
                lane_out[i] = gpio_out[2 + i];
                lane_oe_n[i] = gpio_oe_n[2 + i];
            end
        end
    end
endmodule

// *** tb/qspi_chk.sv ***
`timescale 1ns/1ps
module qspi_chk (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic link_clk,
    input wire logic clk_en,
    input wire logic start,
    input wire logic busy,
    input wire logic done,
    input wire logic tx_take,
    input wire logic rx_valid,
    input wire logic pin_func_select,
    input wire logic [1:0] boot_mode,
    input wire logic clock_idle_polarity,
    input wire logic clock_phase_select,
    input wire logic [5:0] gpio_out,
    input wire logic [5:0] gpio_oe_n,
    input wire logic serial_master_clock,
    input wire logic flash_select_line_n,
    input wire logic [3:0] lane_out,
    input wire logic [3:0] lane_oe_n
);
    // Control handshake in the core domain
    a_start_sets_busy: assert property (@(posedge core_clk) disable iff (rst)
        start && !busy && clk_en |=> busy) else $error("start not taken");
    a_done_single: assert property (@(posedge core_clk) disable iff (rst)
        done |=> !done) else $error("done longer than one cycle");
    a_busy_until_done: assert property (@(posedge core_clk) disable iff (rst)
        $fell(busy) |-> done || $past(done)) else $error("busy dropped without done");
    // Lanes two and three stay general ports in boot mode zero, where the strap does not free them
    a_lanes_boot_zero: assert property (@(posedge core_clk) disable iff (rst)
        boot_mode == 2'h0 |-> lane_oe_n[3:2] == gpio_oe_n[5:4] && lane_out[3:2] == gpio_out[5:4])
        else $error("upper lanes taken in boot mode zero");
    // Link side pulses are one cycle; a byte takes far longer than that
    a_tx_take_pulse: assert property (@(posedge link_clk) disable iff (rst)
        tx_take |=> !tx_take) else $error("tx_take longer than one cycle");
    a_rx_valid_pulse: assert property (@(posedge link_clk) disable iff (rst)
        rx_valid |=> !rx_valid) else $error("rx_valid longer than one cycle");
    // Pins belong to the general ports until the function is selected
    a_gpio_pass: assert property (@(posedge link_clk) disable iff (rst)
        !pin_func_select [*4] |-> serial_master_clock == gpio_out[0]
            && flash_select_line_n == gpio_out[1] && lane_oe_n == gpio_oe_n[5:2])
        else $error("pins not general ports");
    // Clock is back at its idle level when select is negated
    a_idle_level: assert property (@(posedge link_clk) disable iff (rst)
        $rose(flash_select_line_n) && pin_func_select |-> serial_master_clock == clock_idle_polarity)
        else $error("clock not idle at select negation");
    // Data must not move on the edge where the flash latches it
    a_stable_at_rise: assert property (@(posedge link_clk) disable iff (rst)
        $rose(serial_master_clock) && !flash_select_line_n && !lane_oe_n[0]
            && clock_idle_polarity && clock_phase_select |-> $stable(lane_out[0]))
        else $error("data moved on rising clock");
endmodule

// *** tb/flash_model.sv ***
`timescale 1ns/1ps
// Behavioural flash in clock mode three: latches on rise, drives on fall
module flash_model #(
    parameter int ARRAY_BYTES = 64,
    parameter int PAGE_BYTES = 16
) (
    input wire logic sck,
    input wire logic sel_n,
    input wire logic [3:0] din,
    output logic [3:0] dout
);
    logic [7:0] mem [ARRAY_BYTES];
    logic [7:0] cmd = 8'h00;
    logic [7:0] wbyte;
    logic [7:0] rb;
    logic wel = 1'h0;
    logic quad;
    int clks = 0;
    int addr = 0;
    int hdr, dum, j;
    // Frame shape per command code
    assign quad = cmd == 8'h6b || cmd == 8'h32;
    assign dum = cmd == 8'h0b ? 8 : cmd == 8'h6b ? 2 : 0;
    assign hdr = (cmd inside {8'h0b, 8'h6b, 8'hd8, 8'h02, 8'h32}) ? 32 : 8;
    initial
    begin
        dout = 4'h5;
        foreach (mem[i]) mem[i] = 8'(i) ^ 8'ha5;
    end
    // Latch command, address, then program data
    always @(posedge sck)
    begin
        if (clks < 8)
            cmd = {cmd[6:0], din[0]};
        else if (clks < hdr)
            addr = (addr << 1) | din[0];
        else if (wel && (cmd == 8'h02 || cmd == 8'h32))
        begin
            wbyte = quad ? {wbyte[3:0], din} : {wbyte[6:0], din[0]};
            if ((clks - hdr) % (quad ? 2 : 8) == (quad ? 1 : 7))
            begin
                mem[addr % ARRAY_BYTES] = wbyte;
                addr = addr - addr % PAGE_BYTES + (addr + 1) % PAGE_BYTES;
            end
        end
        clks++;
    end
    // Drive read data after the dummy; otherwise a changing pattern
    always @(negedge sck)
    begin
        j = (clks - hdr - dum) * (quad ? 4 : 1);
        rb = mem[(addr + j / 8) % ARRAY_BYTES];
        if ((cmd == 8'h0b || cmd == 8'h6b) && clks >= hdr + dum)
            dout = quad ? rb[7 - j % 8 -: 4] : {2'h0, rb[7 - j % 8], 1'h0};
        else
            dout = ~dout;
    end
    always @(negedge sel_n)
    begin
        clks = 0;
        cmd = 8'h00;
        addr = 0;
    end
    // Bulk erase and write enable latch changes take effect once select is released
    always @(posedge sel_n)
    begin
        dout = ~dout;
        if (clks == 8 && cmd == 8'hc7 && wel)
            foreach (mem[i]) mem[i] = 8'hff;
        if (cmd == 8'h06 || cmd == 8'h04)
            wel = cmd == 8'h06;
        else if (cmd inside {8'h02, 8'h32, 8'hc7, 8'hd8})
            wel = 1'h0;
    end
endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
    logic core_clk = 1'h0, link_clk = 1'h0, rst = 1'h1, clk_en = 1'h1, start = 1'h0;
    logic [3:0][1:0] stage_lanes = '0;
    logic [3:0] stage_read = '0, stage_keep_select = '0;
    logic [3:0][qspi_pkg::DIV_W-1:0] bit_rate_divider = '0;
    logic [3:0][qspi_pkg::LEN_W-1:0] stage_len = '0;
    logic [1:0] last_stage = '0;
    logic clock_idle_polarity = 1'h1, clock_phase_select = 1'h1;
    logic [qspi_pkg::DLY_W-1:0] select_to_clock_delay = 3'h1, select_negate_delay = 3'h0;
    logic [qspi_pkg::DLY_W-1:0] next_access_delay = 3'h2;
    logic pin_func_select = 1'h0;
    logic [1:0] boot_mode = 2'h3;
    logic [5:0] gpio_out = 6'h03, gpio_oe_n = 6'h3c;
    logic [7:0] tx_byte = 8'h00, rx_byte;
    logic busy, done, tx_take, rx_valid, sck, sel_n;
    logic serial_master_clock, serial_master_clock_oe_n, flash_select_line_n, flash_select_line_oe_n;
    logic [3:0] lane_in, lane_out, lane_oe_n, dout;
    logic [7:0] txq [$], rxq [$];
    int failures = 0, compares = 0;
    // Command rows: {write enable latch after, command code}
    logic [8:0] rows [3] = '{{1'h0, qspi_pkg::CMD_WRITE_DISABLE}, {1'h0, qspi_pkg::CMD_BULK_ERASE},
        {1'h1, qspi_pkg::CMD_WRITE_ENABLE}};

    // Core clock, and a slower link clock of unrelated phase
    always #2.5 core_clk = ~core_clk;
    initial
    begin
        #13;
        forever #80 link_clk = ~link_clk;
    end

    quad_spi_flash_master DUT (.*);
    flash_model flash (.sck(sck), .sel_n(sel_n), .din(lane_in), .dout(dout));

    // Released clock and select are pulled high; lanes resolve per driver
    assign sck = serial_master_clock_oe_n ? 1'h1 : serial_master_clock;
    assign sel_n = flash_select_line_oe_n ? 1'h1 : flash_select_line_n;
    assign lane_in = (lane_oe_n & dout) | (~lane_oe_n & lane_out);

    // Byte feed and capture on the link side; no backpressure exists
    always @(posedge link_clk)
    begin
        if (tx_take && txq.size() > 0)
            void'(txq.pop_front());
        if (rx_valid)
            rxq.push_back(rx_byte);
        tx_byte <= (txq.size() > 0) ? txq[0] : 8'h00;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic stg(input int s, input logic [1:0] ln, input logic rd, input logic keep,
                       input logic [qspi_pkg::DIV_W-1:0] dv, input int bits);
        @(posedge core_clk);
        stage_lanes[s] <= ln;
        stage_read[s] <= rd;
        stage_keep_select[s] <= keep;
        bit_rate_divider[s] <= dv;
        stage_len[s] <= qspi_pkg::LEN_W'(bits);
    endtask

    // One sequence, with a second start thrown in while busy
    task automatic run(input logic [1:0] last, input logic [7:0] bytes [$]);
        int n;
        txq = bytes;
        rxq = {};
        @(posedge core_clk);
        last_stage <= last;
        start <= 1'h1;
        @(posedge core_clk);
        start <= 1'h0;
        repeat (20) @(posedge core_clk);
        start <= 1'h1;
        @(posedge core_clk);
        start <= 1'h0;
        n = 0;
        do
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
        while (done !== 1'h1 && n < 30000);
        repeat (4) @(posedge core_clk);
        #1;
        chk("one sequence", 2'h2, {n < 30000, busy});
    endtask

    task automatic end_of_test();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Hang guard, well beyond the expected run length
    initial
    begin
        repeat (60000) @(posedge core_clk);
        failures++;
        end_of_test();
    end

    initial
    begin
        repeat (6) @(posedge core_clk);
        repeat (2) @(posedge link_clk);
        @(posedge core_clk);
        rst <= 1'h0;
        repeat (4) @(posedge link_clk);
        #1;
        chk("gpio pins", {gpio_oe_n[5:2], 2'h3}, {lane_oe_n, sck, sel_n});
        @(posedge core_clk);
        pin_func_select <= 1'h1;
        repeat (4) @(posedge link_clk);
        for (int i = 0; i < 3; i++)
        begin
            stg(0, qspi_pkg::LANES_SINGLE, 1'h0, 1'h0, 12'h001, 8);
            run(2'h0, '{rows[i][7:0]});
            chk("command", rows[i], {flash.wel, flash.cmd});
            chk("beats", 8 + 256, flash.clks + (rxq.size() << 8));
        end
        // Fast read over the array end; ratio 3 leaves time for the pin synchroniser
        stg(0, qspi_pkg::LANES_SINGLE, 1'h0, 1'h0, 12'h003, 56);
        run(2'h0, '{qspi_pkg::CMD_FAST_READ, 8'h00, 8'h00, 8'h3f, 8'h00, 8'h00, 8'h00});
        chk("read wrap", {8'h3f ^ 8'ha5, 8'ha5}, {rxq[5], rxq[6]});
        // Four-lane read spread over three stages under one select
        stg(0, qspi_pkg::LANES_SINGLE, 1'h0, 1'h1, 12'h002, 32);
        stg(1, qspi_pkg::LANES_QUAD, 1'h1, 1'h1, 12'h003, 8);
        stg(2, qspi_pkg::LANES_QUAD, 1'h1, 1'h0, 12'h003, 32);
        run(2'h2, '{qspi_pkg::CMD_QUAD_OUT_READ, 8'h00, 8'h00, 8'h10});
        chk("quad read", {8'h10, 8'h11, 8'h12, 8'h13} ^ {4{8'ha5}},
            {rxq[5], rxq[6], rxq[7], rxq[8]});
        // Four-lane program across the page end
        stg(0, qspi_pkg::LANES_SINGLE, 1'h0, 1'h1, 12'h002, 32);
        stg(1, qspi_pkg::LANES_QUAD, 1'h0, 1'h0, 12'h001, 24);
        run(2'h1, '{qspi_pkg::CMD_QUAD_PAGE_PROGRAM, 8'h00, 8'h00, 8'h0f, 8'h11, 8'h22, 8'h33});
        chk("page wrap", 24'h112233, {flash.mem[15], flash.mem[0], flash.mem[1]});
        // Boot strap zero keeps lanes two and three as ports
        @(posedge core_clk);
        rst <= 1'h1;
        boot_mode <= 2'h0;
        repeat (2) @(posedge link_clk);
        @(posedge core_clk);
        rst <= 1'h0;
        repeat (4) @(posedge link_clk);
        stg(0, qspi_pkg::LANES_QUAD, 1'h1, 1'h0, 12'h002, 8);
        run(2'h0, '{8'h00});
        chk("boot lanes", gpio_oe_n[5:4], lane_oe_n[3:2]);
        end_of_test();
    end
endmodule

bind quad_spi_flash_master qspi_chk chk (.*);
